/* File: timer_pkg.sv */
package timer_pkg;

	localparam int TIMER_COUNT      = 512;
	localparam int INDEX_W          = 9;
	localparam int COUNT_W          = 32;
	localparam int LEVEL_W          = 6;

	// entry layout in the state store
	localparam int COUNT_LSB        = 0;
	localparam int RUN_POS          = 32;
	localparam int HOLD_POS         = 33;
	localparam int MODE_LSB         = 34;
	localparam int MODE_W           = 2;
	localparam int PREV_LSB         = 36;
	localparam int ENTRY_W          = 42;

	// input level bits inside a level group
	localparam int LVL_GATE         = 0;
	localparam int LVL_CLEAR        = 1;
	localparam int LVL_T1           = 2;
	localparam int LVL_T2           = 3;
	localparam int LVL_T3           = 4;
	localparam int LVL_T4           = 5;

	localparam logic [ENTRY_W-1:0] ENTRY_RESET = 42'h000_0000_0000;
	localparam logic [COUNT_W-1:0] COUNT_RESET = 32'h0000_0000;

	// tick timing
	localparam int CLK_FREQ_KHZ     = 100000;
	localparam int TICK_TIME_MS     = 1;
	localparam int TICK_CYCLES      = CLK_FREQ_KHZ * TICK_TIME_MS;
	localparam int TICK_W           = 17;

	typedef enum logic [MODE_W-1:0]
	{
		MODE_ONE_SHOT,
		MODE_ON_DELAY,
		MODE_OFF_DELAY,
		MODE_PULSE_LIMIT
	} mode_type;

endpackage

/* File: timer_store.sv */
`timescale 1ns/10ps
module timer_store
#(
	parameter int WIDTH  = 42,
	parameter int DEPTH  = 512,
	parameter int ADDR_W = 9
)
(
	// clock
	input  wire logic              clk,
	// write port
	input  wire logic              writeEnable,
	input  wire logic [ADDR_W-1:0] writeAddr,
	input  wire logic [WIDTH-1:0]  writeData,
	// registered read ports
	input  wire logic [ADDR_W-1:0] readAddrA,
	output logic      [WIDTH-1:0]  readDataA,
	input  wire logic [ADDR_W-1:0] readAddrB,
	output logic      [WIDTH-1:0]  readDataB
);

	logic [WIDTH-1:0] mem [DEPTH];

	// read before write on a shared address
	always_ff @(posedge clk)
	begin
		if (writeEnable)
			mem[writeAddr] <= writeData;
		readDataA <= mem[readAddrA];
		readDataB <= mem[readAddrB];
	end

endmodule

/* File: plc_timer_bank.sv */
`timescale 1ns/10ps
// Notes on behaviour
// RULE_01 - 512 timers, each with own inputs, status and elapsed count.
// RULE_02 - startup reset clears every status and elapsed count to zero.
// RULE_03 - gate low after trigger freezes timing; resumes from held value.
// RULE_04 - triggering forces the timer's gate to active high by default.
// RULE_05 - triggering treats the clear input as inactive by default.
// RULE_06 - clear rise drops status, zeroes count; timer stays inactive.
// RULE_07 - four triggers select one-shot, on-delay, off-delay, pulse-limit.
// RULE_08 - time constant is unsigned milliseconds, 0 to 4294967295.
// RULE_09 - status bit and elapsed count are readable at any time.
// RULE_10 - one-shot rising edge sets status high and restarts count at 0.
// RULE_11 - one-shot at constant: stop, status low, count held.
// RULE_12 - one-shot trigger edges while running are ignored.
// RULE_13 - completed one-shot restarts only on a fresh rising edge.
// RULE_14 - on-delay rising edge starts count at 0, status stays low.
// RULE_15 - on-delay at constant: stop, status high until trigger falls.
// RULE_16 - on-delay count held until next rising edge restarts it.
// RULE_17 - on-delay early falling edge stops timing, keeps count, status low.
// RULE_18 - running enabled timers count once per 1 ms; edges vs prior level.
// RULE_19 - paused timer keeps status; comparison resumes with counting.
module plc_timer_bank
	import timer_pkg::*;
#(
	parameter int TICK_DIV = timer_pkg::TICK_CYCLES
)
(
	// clock and reset
	input  wire logic                          clk,
	input  wire logic                          reset,
	// per-timer control levels, bit i is timer i+1
	input  wire logic [timer_pkg::TIMER_COUNT-1:0] runGate,
	input  wire logic [timer_pkg::TIMER_COUNT-1:0] clearInput,
	input  wire logic [timer_pkg::TIMER_COUNT-1:0] oneShotTrigger,
	input  wire logic [timer_pkg::TIMER_COUNT-1:0] onDelayTrigger,
	input  wire logic [timer_pkg::TIMER_COUNT-1:0] offDelayTrigger,
	input  wire logic [timer_pkg::TIMER_COUNT-1:0] pulseLimitTrigger,
	// time constant load
	input  wire logic                          constWrite,
	input  wire logic [timer_pkg::INDEX_W-1:0] constIndex,
	input  wire logic [timer_pkg::COUNT_W-1:0] constValue,
	// status and elapsed count
	output logic      [timer_pkg::TIMER_COUNT-1:0] timerStatus,
	input  wire logic [timer_pkg::INDEX_W-1:0] countIndex,
	output logic      [timer_pkg::COUNT_W-1:0] countValue,
	output logic                               ready
);

	import timer_pkg::*;

	localparam logic [INDEX_W-1:0] LAST_INDEX = INDEX_W'(TIMER_COUNT - 1);
	localparam logic [TICK_W-1:0]  TICK_LAST  = TICK_W'(TICK_DIV - 1);

	logic [INDEX_W-1:0] scanIdx_reg;
	logic [INDEX_W-1:0] visitIdx_reg;
	logic               visitValid_reg;
	logic               initializing_reg;
	logic [TICK_W-1:0]  tickCount_reg;
	logic               tickReq_reg;
	logic               passTick_reg;
	logic [TIMER_COUNT-1:0] status_reg;
	logic [COUNT_W-1:0] countValue_reg;

	logic [ENTRY_W-1:0] entryRead;
	logic [ENTRY_W-1:0] countRead;
	logic [COUNT_W-1:0] timeConst;
	logic [ENTRY_W-1:0] entryNext;
	logic               statusNext;
	logic               storeWrite;
	logic [INDEX_W-1:0] storeAddr;
	logic [ENTRY_W-1:0] storeData;

	// whole bank is swept one entry per clock, so a level change shorter
	// than one sweep can be missed; that is the scan-time limitation
	timer_store #(
		.WIDTH  (ENTRY_W),
		.DEPTH  (TIMER_COUNT),
		.ADDR_W (INDEX_W)
	) stateStore (
		.clk         (clk),
		.writeEnable (storeWrite),
		.writeAddr   (storeAddr),
		.writeData   (storeData),
		.readAddrA   (scanIdx_reg),
		.readDataA   (entryRead),
		.readAddrB   (countIndex),
		.readDataB   (countRead)
	); // RULE_01

	timer_store #(
		.WIDTH  (COUNT_W),
		.DEPTH  (TIMER_COUNT),
		.ADDR_W (INDEX_W)
	) constStore (
		.clk         (clk),
		.writeEnable (constWrite),
		.writeAddr   (constIndex),
		.writeData   (constValue),
		.readAddrA   (scanIdx_reg),
		.readDataA   (timeConst),
		.readAddrB   (constIndex),
		.readDataB   ()
	); // RULE_08

	// decode of the visited entry
	wire logic [COUNT_W-1:0] curCount = entryRead[COUNT_LSB +: COUNT_W];
	wire logic               curRun   = entryRead[RUN_POS];
	wire logic               curHold  = entryRead[HOLD_POS];
	wire mode_type           curMode  =
		mode_type'(entryRead[MODE_LSB +: MODE_W]);
	wire logic [LEVEL_W-1:0] prevLvl  = entryRead[PREV_LSB +: LEVEL_W];
	wire logic               curStat  = status_reg[visitIdx_reg];

	wire logic [LEVEL_W-1:0] lvl = {
		pulseLimitTrigger[visitIdx_reg],
		offDelayTrigger[visitIdx_reg],
		onDelayTrigger[visitIdx_reg],
		oneShotTrigger[visitIdx_reg],
		clearInput[visitIdx_reg],
		runGate[visitIdx_reg]
	};
	wire logic [LEVEL_W-1:0] rise = lvl & ~prevLvl; // RULE_18
	wire logic [LEVEL_W-1:0] fall = ~lvl & prevLvl; // RULE_18

	wire logic oneShotBusy = curRun && curMode == MODE_ONE_SHOT;
	wire logic fireOne     = rise[LVL_T1] && !oneShotBusy; // RULE_12 RULE_13
	wire logic effGate     = lvl[LVL_GATE] || curHold; // RULE_04
	wire logic atConst     = curCount >= timeConst; // RULE_11
	wire logic [COUNT_W-1:0] countInc = curCount + COUNT_W'(1);

	always_comb
	begin
		logic [COUNT_W-1:0] nCount;
		logic               nRun;
		logic               nHold;
		mode_type           nMode;
		logic               nStat;
		logic [LEVEL_W-1:0] nPrev;
		nCount = curCount;
		nRun   = curRun;
		nHold  = curHold && !fall[LVL_GATE];
		nMode  = curMode;
		nStat  = curStat;
		nPrev  = lvl;
		if (rise[LVL_CLEAR])
		begin
			nCount = COUNT_RESET; // RULE_06
			nRun   = 1'b0; // RULE_06
			nStat  = 1'b0; // RULE_06
			nHold  = 1'b0;
		end
		else if (fireOne)
		begin
			nMode  = MODE_ONE_SHOT; // RULE_07
			nRun   = 1'b1; // RULE_10
			nCount = COUNT_RESET; // RULE_10
			nStat  = 1'b1; // RULE_10
			nHold  = 1'b1; // RULE_04
		end
		else if (rise[LVL_T2])
		begin
			nMode  = MODE_ON_DELAY; // RULE_07
			nRun   = 1'b1; // RULE_14
			nCount = COUNT_RESET; // RULE_14
			nStat  = 1'b0; // RULE_14
			nHold  = 1'b1; // RULE_04
		end
		else if (rise[LVL_T3])
		begin
			nMode  = MODE_OFF_DELAY; // RULE_07
			nRun   = 1'b0;
			nCount = COUNT_RESET;
			nStat  = 1'b1;
			nHold  = 1'b1; // RULE_04
		end
		else if (rise[LVL_T4])
		begin
			nMode  = MODE_PULSE_LIMIT; // RULE_07
			nRun   = 1'b1;
			nCount = COUNT_RESET;
			nStat  = 1'b1;
			nHold  = 1'b1; // RULE_04
		end
		else if (curMode == MODE_ON_DELAY && fall[LVL_T2])
		begin
			nRun  = 1'b0; // RULE_17
			nStat = 1'b0; // RULE_15
		end
		else if (curMode == MODE_OFF_DELAY && fall[LVL_T3] && curStat)
		begin
			nRun   = 1'b1;
			nCount = COUNT_RESET;
		end
		else if (curMode == MODE_PULSE_LIMIT && fall[LVL_T4] && curRun)
		begin
			nRun  = 1'b0;
			nStat = 1'b0;
		end
		else if (curRun && effGate) // RULE_03 RULE_19
		begin
			if (atConst)
			begin
				nRun  = 1'b0; // RULE_11 RULE_15 RULE_16
				nStat = curMode == MODE_ON_DELAY; // RULE_11 RULE_15
			end
			else if (passTick_reg)
				nCount = countInc; // RULE_18
		end
		// an already-high clear at trigger time gives no edge later
		if (fireOne || (|rise[LVL_T4:LVL_T2]))
			nPrev[LVL_CLEAR] = lvl[LVL_CLEAR]; // RULE_05
		entryNext = {nPrev, MODE_W'(nMode), nHold, nRun, nCount};
		statusNext = nStat;
	end

	assign storeWrite = initializing_reg || visitValid_reg;
	assign storeAddr  = initializing_reg ? scanIdx_reg : visitIdx_reg;
	assign storeData  = initializing_reg ? ENTRY_RESET : entryNext; // RULE_02

	wire logic tickNow = tickCount_reg == TICK_LAST;
	wire logic passStart = scanIdx_reg == '0;

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			scanIdx_reg      <= '0;
			visitIdx_reg     <= '0;
			visitValid_reg   <= 1'b0;
			initializing_reg <= 1'b1;
		end
		else
		begin
			scanIdx_reg      <= scanIdx_reg + INDEX_W'(1);
			visitIdx_reg     <= scanIdx_reg;
			visitValid_reg   <= !initializing_reg;
			if (scanIdx_reg == LAST_INDEX)
				initializing_reg <= 1'b0;
		end
	end

	// a tick that lands mid-sweep is applied to the whole next sweep
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			tickCount_reg <= '0;
			tickReq_reg   <= 1'b0;
			passTick_reg  <= 1'b0;
		end
		else
		begin
			tickCount_reg <= tickNow ? '0 : tickCount_reg + TICK_W'(1);
			if (passStart)
				passTick_reg <= tickReq_reg; // RULE_18
			if (tickNow)
				tickReq_reg <= 1'b1;
			else if (passStart)
				tickReq_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset)
			status_reg <= '0; // RULE_02
		else if (visitValid_reg)
			status_reg[visitIdx_reg] <= statusNext;
	end

	always_ff @(posedge clk)
	begin
		if (reset || initializing_reg)
			countValue_reg <= COUNT_RESET; // RULE_02
		else
			countValue_reg <= countRead[COUNT_LSB +: COUNT_W]; // RULE_09
	end

	assign timerStatus = status_reg; // RULE_09
	assign countValue  = countValue_reg;
	assign ready       = visitValid_reg;

endmodule

/* File: plc_timer_chk.sv */
`timescale 1ns/10ps
module plc_timer_chk
(
	// clock and reset
	input wire logic                               clk,
	input wire logic                               reset,
	// watched ports
	input wire logic [timer_pkg::TIMER_COUNT-1:0] clearInput,
	input wire logic [timer_pkg::TIMER_COUNT-1:0] oneShotTrigger,
	input wire logic [timer_pkg::TIMER_COUNT-1:0] onDelayTrigger,
	input wire logic [timer_pkg::TIMER_COUNT-1:0] timerStatus,
	input wire logic [timer_pkg::INDEX_W-1:0]     countIndex,
	input wire logic [timer_pkg::COUNT_W-1:0]     countValue,
	input wire logic                               ready
);
	import timer_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	property p_init;
		!ready |-> timerStatus == '0 && countValue == '0;
	endproperty
	a_init: assert property (p_init) else $error("init");
	property p_rdy;
		$fell(reset) |-> ##[1:600] ready;
	endproperty
	a_rdy: assert property (p_rdy) else $error("ready late");
	property p_hold;
		ready |=> ready;
	endproperty
	a_hold: assert property (p_hold) else $error("ready lost");
	// one visit per timer per pass, so no status can move twice in a row
	property p_gap;
		$changed(timerStatus[0]) |=> $stable(timerStatus[0])[*8];
	endproperty
	a_gap: assert property (p_gap) else $error("status twitch");
	property p_clr;
		ready && $rose(clearInput[0]) |-> ##[1:520] !timerStatus[0];
	endproperty
	a_clr: assert property (p_clr) else $error("clear");
	property p_os;
		ready && $rose(oneShotTrigger[0]) && !timerStatus[0]
			|-> ##[1:520] timerStatus[0];
	endproperty
	a_os: assert property (p_os) else $error("one-shot");
	property p_od;
		ready && $rose(onDelayTrigger[0]) && !timerStatus[0]
			|=> !timerStatus[0][*8];
	endproperty
	a_od: assert property (p_od) else $error("on-delay");
	// count read with latency 2, so index must be steady three back
	property p_step;
		ready && $past(countIndex, 2) == $past(countIndex, 3)
			&& $changed(countValue)
			|-> countValue == $past(countValue) + 1 || countValue == '0;
	endproperty
	a_step: assert property (p_step) else $error("count step");
	c_os: cover property ($rose(timerStatus[0]));
	c_od: cover property ($fell(onDelayTrigger[0]));
	c_clr: cover property (ready && $rose(clearInput[0]));
endmodule
bind plc_timer_bank plc_timer_chk chk (.clk, .reset, .clearInput,
	.oneShotTrigger, .onDelayTrigger, .timerStatus, .countIndex,
	.countValue, .ready);

/* File: ctrl_program.sv */
`timescale 1ns/10ps
module ctrl_program
(
	// clock
	input wire logic                           clk,
	// per-timer levels, bit i is timer i+1
	output logic [timer_pkg::TIMER_COUNT-1:0] gate,
	output logic [timer_pkg::TIMER_COUNT-1:0] clr,
	output logic [timer_pkg::TIMER_COUNT-1:0] t1,
	output logic [timer_pkg::TIMER_COUNT-1:0] t2,
	output logic [timer_pkg::TIMER_COUNT-1:0] t3,
	output logic [timer_pkg::TIMER_COUNT-1:0] t4
);
	import timer_pkg::*;
	logic [TIMER_COUNT-1:0] lv [6] = '{default: '0};
	assign gate = lv[LVL_GATE];
	assign clr = lv[LVL_CLEAR];
	assign t1 = lv[LVL_T1];
	assign t2 = lv[LVL_T2];
	assign t3 = lv[LVL_T3];
	assign t4 = lv[LVL_T4];
	// levels move off the edge; callers hold them past a visit
	task automatic put(input int k, input int i, input logic v);
		@(posedge clk);
		#1 lv[k][i] = v;
	endtask
endmodule

/* File: plc_timer_oneshot_ondelay_tb_top.sv */
`timescale 1ns/10ps
module plc_timer_oneshot_ondelay_tb_top;
	import timer_pkg::*;
	logic                   clk = 1'b0;
	logic                   reset = 1'b1;
	logic                   cw = 1'b0;
	logic [INDEX_W-1:0]     ci = '0;
	logic [INDEX_W-1:0]     ri = '0;
	logic [COUNT_W-1:0]     cv = '0;
	logic [COUNT_W-1:0]     x;
	logic [COUNT_W-1:0]     y;
	logic [COUNT_W-1:0]     cnt;
	logic [TIMER_COUNT-1:0] g, c, a, b, d, e, st;
	logic                   rdy;
	int                     n_errors = 0;
	int                     n_compared = 0;
	always #5 clk = ~clk;
	ctrl_program prog (.clk, .gate(g), .clr(c), .t1(a), .t2(b), .t3(d),
		.t4(e));
	// one tick per pass keeps counts short
	plc_timer_bank #(.TICK_DIV(512)) dut (.clk, .reset, .runGate(g),
		.clearInput(c), .oneShotTrigger(a), .onDelayTrigger(b),
		.offDelayTrigger(d), .pulseLimitTrigger(e), .constWrite(cw),
		.constIndex(ci), .constValue(cv), .timerStatus(st),
		.countIndex(ri), .countValue(cnt), .ready(rdy));
	task automatic cmp(input string s, input logic [31:0] ex,
		input logic [31:0] got);
		n_compared++;
		if (got !== ex)
		begin
			n_errors++;
			$display("[ERR] %s exp %0h got %0h", s, ex, got);
		end
	endtask
	// bounded poll: status may lag an input by a full pass
	task automatic wst(input int i, input logic v, input int n);
		repeat (n)
			if (st[i] !== v)
			begin
				@(posedge clk);
				#1;
			end
		cmp("status", {31'h0, v}, {31'h0, st[i]});
	endtask
	task automatic rd(input int i, output logic [31:0] v);
		@(posedge clk);
		#1 ri = i[INDEX_W-1:0];
		repeat (3) @(posedge clk);
		#1 v = cnt;
	endtask
	task automatic wc(input int i, input logic [31:0] v);
		@(posedge clk);
		#1 cw = 1'b1;
		ci = i[INDEX_W-1:0];
		cv = v;
		@(posedge clk);
		#1 cw = 1'b0;
	endtask
	task automatic end_of_test;
		if (n_errors == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial
	begin
		repeat (60000) @(posedge clk);
		n_errors++;
		end_of_test();
	end
	initial
	begin
		repeat (4) @(posedge clk);
		#1 reset = 1'b0;
		repeat (600) if (rdy !== 1'b1) @(posedge clk);
		cmp("idle", 0, {31'h0, |st});
		rd(511, x);
		cmp("count", 0, x);
		wc(0, 32'h0000_0005);
		prog.put(LVL_GATE, 0, 1'b1);
		prog.put(LVL_T1, 0, 1'b1);
		wst(0, 1'b1, 600);
		rd(0, x);
		cmp("start", 1, {31'h0, x <= 1});
		prog.put(LVL_T1, 0, 1'b0);
		repeat (600) @(posedge clk);
		prog.put(LVL_T1, 0, 1'b1);
		wst(0, 1'b1, 600);
		wst(0, 1'b0, 4000);
		rd(0, x);
		cmp("final", 1, {31'h0, x >= 5 && x <= 6});
		repeat (1100) @(posedge clk);
		rd(0, y);
		cmp("held", x, y);
		prog.put(LVL_T1, 0, 1'b0);
		repeat (600) @(posedge clk);
		prog.put(LVL_T1, 0, 1'b1);
		wst(0, 1'b1, 600);
		prog.put(LVL_CLEAR, 0, 1'b1);
		wst(0, 1'b0, 600);
		rd(0, x);
		cmp("cleared", 0, x);
		repeat (1100) @(posedge clk);
		wst(0, 1'b0, 1);
		prog.put(LVL_T1, 0, 1'b0);
		repeat (600) @(posedge clk);
		prog.put(LVL_T1, 0, 1'b1);
		wst(0, 1'b1, 600);
		wst(0, 1'b0, 4000);
		prog.put(LVL_CLEAR, 0, 1'b0);
		wc(0, 32'h0000_0003);
		prog.put(LVL_T2, 0, 1'b1);
		repeat (600) @(posedge clk);
		wst(0, 1'b0, 1);
		wst(0, 1'b1, 3000);
		rd(0, x);
		repeat (1100) @(posedge clk);
		rd(0, y);
		cmp("held", x, y);
		prog.put(LVL_T2, 0, 1'b0);
		wst(0, 1'b0, 600);
		wc(0, 32'h0000_0032);
		prog.put(LVL_T2, 0, 1'b1);
		repeat (1600) @(posedge clk);
		prog.put(LVL_T2, 0, 1'b0);
		repeat (600) @(posedge clk);
		rd(0, x);
		repeat (1100) @(posedge clk);
		rd(0, y);
		cmp("early", x, y);
		cmp("early", 1, {31'h0, x > 0 && x < 50});
		wst(0, 1'b0, 1);
		wc(511, 32'h0000_000A);
		prog.put(LVL_T1, 511, 1'b1);
		wst(511, 1'b1, 600);
		repeat (1100) @(posedge clk);
		prog.put(LVL_GATE, 511, 1'b1);
		repeat (600) @(posedge clk);
		prog.put(LVL_GATE, 511, 1'b0);
		repeat (600) @(posedge clk);
		rd(511, x);
		repeat (2100) @(posedge clk);
		rd(511, y);
		cmp("paused", x, y);
		wst(511, 1'b1, 1);
		prog.put(LVL_GATE, 511, 1'b1);
		wst(511, 1'b0, 8000);
		wc(1, 32'hFFFF_FFFF);
		prog.put(LVL_T4, 1, 1'b1);
		wst(1, 1'b1, 600);
		prog.put(LVL_T4, 1, 1'b0);
		wst(1, 1'b0, 600);
		prog.put(LVL_T3, 1, 1'b1);
		wst(1, 1'b1, 600);
		end_of_test();
	end
endmodule
